// ===== core/mcct_top.sv
/*
  Six-channel 16-bit capture/compare timer core with plain control ports.
  Assumes all inputs synchronous to clk_sys and software-style pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcct_cfg.svh"
module mcct_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire mcct_pkg::mcct_chmask_t run_bits,
  input wire mcct_pkg::mcct_chmask_t sync_bits,
  input wire logic [11:0] clk_sel,
  input wire logic [17:0] clear_sel,
  input wire mcct_pkg::mcct_grmask_t gr_capture_mode,
  input wire logic [47:0] gr_out_mode,
  input wire logic [47:0] gr_edge_sel,
  input wire logic [47:0] gr_cap_src,
  input wire logic [3:0] buffer_en,
  input wire mcct_pkg::mcct_chmask_t irq_ovf_en,
  input wire mcct_pkg::mcct_grmask_t irq_match_en,
  input wire mcct_pkg::mcct_chmask_t ext_clk_in,
  input wire mcct_pkg::mcct_grmask_t pin_in,
  input wire logic cnt_wr_en,
  input wire mcct_pkg::mcct_chidx_t cnt_wr_chan,
  input wire mcct_pkg::mcct_word_t cnt_wr_data,
  input wire logic gr_wr_en,
  input wire mcct_pkg::mcct_gridx_t gr_wr_idx,
  input wire mcct_pkg::mcct_word_t gr_wr_data,
  input wire mcct_pkg::mcct_gridx_t gr_rd_idx,
  input wire mcct_pkg::mcct_chmask_t flag_clr_ovf,
  input wire mcct_pkg::mcct_grmask_t flag_clr_match,
  output var logic [95:0] cnt_value,
  output var mcct_pkg::mcct_word_t gr_rd_data,
  output var mcct_pkg::mcct_chmask_t overflow_flag,
  output var mcct_pkg::mcct_grmask_t match_capture_flag,
  output var mcct_pkg::mcct_chmask_t irq_req,
  output var mcct_pkg::mcct_grmask_t pin_out,
  output var mcct_pkg::mcct_grmask_t pin_oe
);
  import mcct_pkg::*;

  mcct_gr_if gr();

  mcct_gr_bank u_bank (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .gr(gr.bank)
  );

  logic [3:0] pre_r;
  mcct_chmask_t ext_prev_r;
  mcct_grmask_t pin_prev_r;
  logic [17:0] clr_cfg_r;
  mcct_chmask_t tick;
  mcct_chmask_t cnt_go;
  mcct_chmask_t own_clr;
  mcct_chmask_t clr;
  mcct_chmask_t preset;
  mcct_chmask_t ovf;
  mcct_grmask_t hit;
  mcct_grmask_t cap;
  mcct_grmask_t evt;
  logic sync_evt;

  // Capture partner: 0<->1, 3<->4; others have none
  function automatic int partner(input int ch);
    case (ch)
      0: return 1;
      1: return 0;
      3: return 4;
      4: return 3;
      default: return ch;
    endcase
  endfunction

  // Channels 1,2,4,5 own only registers A and B
  function automatic logic gr_exists(input int g);
    return (g / 4 == 0) || (g / 4 == 3) || (g % 4 < 2);
  endfunction

  // Buffer enable for the A/C or B/D pair of register g
  function automatic logic buf_on(input int g, input logic [3:0] ben);
    if (g / 4 == 0)
      return ben[g % 2];
    else if (g / 4 == 3)
      return ben[2 + g % 2];
    else
      return 1'b0;
  endfunction

  function automatic logic [15:0] cnt_of(input logic [95:0] v, input int ch);
    return v[ch * 16 +: 16];
  endfunction

  // Prescaler shared by all channels
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pre_r <= `MCCT_PRE_RST;
    else
      pre_r <= pre_r + 4'h1;
  end

  // Edge history of external clocks and capture pins
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_prev_r <= '0;
      pin_prev_r <= '0;
    end
    else
    begin
      ext_prev_r <= ext_clk_in;
      pin_prev_r <= pin_in;
    end
  end

  // Clear selection held in a flop so reset leaves free-running mode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      clr_cfg_r <= {`MCCT_NCH{`MCCT_CLR_NONE}};
    else
      clr_cfg_r <= clear_sel;
  end

  // Count clock per channel
  always_comb
  begin
    for (int ch = 0; ch < `MCCT_NCH; ch++)
    begin
      case (clk_sel[ch * 2 +: 2])
        `MCCT_CK_DIV1: tick[ch] = 1'b1;
        `MCCT_CK_DIV4: tick[ch] = (pre_r[1:0] == `MCCT_DIV4_TAP);
        `MCCT_CK_DIV16: tick[ch] = (pre_r == `MCCT_DIV16_TAP);
        default: tick[ch] = ext_clk_in[ch] & ~ext_prev_r[ch];
      endcase
    end
    cnt_go = run_bits & tick;
  end

  // Compare match, only on a counting edge so flag, pin and clear coincide
  always_comb
  begin
    for (int g = 0; g < `MCCT_NGR; g++)
    begin
      hit[g] = gr_exists(g) && !gr_capture_mode[g] && cnt_go[g / 4]
        && !(g % 4 >= 2 && buf_on(g, buffer_en))
        && (cnt_of(cnt_value, g / 4) == gr.q[g]);
    end
  end

  // Input capture from pin edges or partner channel
  always_comb
  begin
    for (int g = 0; g < `MCCT_NGR; g++)
    begin
      logic rise;
      logic fall;
      logic ok;
      int p;
      rise = pin_in[g] & ~pin_prev_r[g];
      fall = ~pin_in[g] & pin_prev_r[g];
      p = partner(g / 4);
      ok = gr_exists(g) && gr_capture_mode[g] && !(g % 4 >= 2 && buf_on(g, buffer_en));
      case (gr_cap_src[g * 2 +: 2])
        `MCCT_SRC_PIN:
        begin
          case (gr_edge_sel[g * 2 +: 2])
            `MCCT_EDGE_RISE: cap[g] = ok && rise;
            `MCCT_EDGE_FALL: cap[g] = ok && fall;
            `MCCT_EDGE_BOTH: cap[g] = ok && (rise || fall);
            default: cap[g] = 1'b0;
          endcase
        end
        `MCCT_SRC_PCLK:
          cap[g] = ok && (p != g / 4) && tick[p]
            && !((g / 4 == 0 || g / 4 == 3)
            && clk_sel[p * 2 +: 2] == `MCCT_CK_DIV1);
        `MCCT_SRC_PMATCH:
          cap[g] = ok && (p != g / 4) && hit[p * 4];
        default: cap[g] = 1'b0;
      endcase
    end
    evt = hit | cap;
  end

  // Clearing, synchronous clearing and presetting
  always_comb
  begin
    for (int ch = 0; ch < `MCCT_NCH; ch++)
    begin
      logic [2:0] cs;
      cs = clr_cfg_r[ch * 3 +: 3];
      if (cs >= `MCCT_CLR_A && cs <= `MCCT_CLR_D)
        own_clr[ch] = evt[ch * 4 + int'(cs) - 1];
      else
        own_clr[ch] = 1'b0;
    end
    // Software must pair channels and pick a source for this to fire
    sync_evt = |(own_clr & sync_bits);
    for (int ch = 0; ch < `MCCT_NCH; ch++)
    begin
      clr[ch] = own_clr[ch] || (sync_bits[ch] && sync_evt
        && clr_cfg_r[ch * 3 +: 3] == `MCCT_CLR_SYNC);
      preset[ch] = cnt_wr_en && (cnt_wr_chan == 3'(ch)
        || (sync_bits[ch] && sync_bits[cnt_wr_chan]));
      ovf[ch] = cnt_go[ch] && !clr[ch] && !preset[ch]
        && cnt_of(cnt_value, ch) == `MCCT_CNT_MAX;
    end
  end

  // Counters: preset over clear over count
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cnt_value <= {`MCCT_NCH{`MCCT_CNT_RST}};
    else
    begin
      for (int ch = 0; ch < `MCCT_NCH; ch++)
      begin
        if (preset[ch])
          cnt_value[ch * 16 +: 16] <= cnt_wr_data;
        else if (clr[ch])
          cnt_value[ch * 16 +: 16] <= `MCCT_CNT_RST;
        else if (cnt_go[ch])
          cnt_value[ch * 16 +: 16] <= cnt_of(cnt_value, ch) + 16'h1;
      end
    end
  end

  // General register writes; hardware transfers override software
  always_comb
  begin
    gr.rd_idx = gr_rd_idx;
    for (int g = 0; g < `MCCT_NGR; g++)
    begin
      gr.we[g] = gr_wr_en && gr_wr_idx == 5'(g) && gr_exists(g);
      gr.wd[g] = gr_wr_data;
    end
    for (int g = 0; g < `MCCT_NGR; g++)
    begin
      if (cap[g])
      begin
        gr.we[g] = 1'b1;
        gr.wd[g] = cnt_of(cnt_value, g / 4);
        if (g % 4 < 2 && buf_on(g, buffer_en))
        begin
          gr.we[g + 2] = 1'b1;
          gr.wd[g + 2] = gr.q[g];
        end
      end
      else if (hit[g] && g % 4 < 2 && buf_on(g, buffer_en))
      begin
        gr.we[g] = 1'b1;
        gr.wd[g] = gr.q[g + 2];
      end
    end
  end

  assign gr_rd_data = gr.rd_data;

  // Flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      overflow_flag <= '0;
      match_capture_flag <= '0;
    end
    else
    begin
      overflow_flag <= ovf | (overflow_flag & ~flag_clr_ovf);
      match_capture_flag <= evt | (match_capture_flag & ~flag_clr_match);
    end
  end

  // Interrupt request per channel, one edge behind the flags
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq_req <= '0;
    else
    begin
      for (int ch = 0; ch < `MCCT_NCH; ch++)
        irq_req[ch] <= (overflow_flag[ch] && irq_ovf_en[ch])
          || |(match_capture_flag[ch * 4 +: 4] & irq_match_en[ch * 4 +: 4]);
    end
  end

  // Waveform pins; a stopped counter keeps its last level
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      for (int g = 0; g < `MCCT_NGR; g++)
      begin
        pin_oe[g] <= gr_exists(g) && !gr_capture_mode[g]
          && gr_out_mode[g * 2 +: 2] != `MCCT_OUT_NONE;
        if (hit[g])
        begin
          // Driving the level the pin already has changes nothing
          case (gr_out_mode[g * 2 +: 2])
            `MCCT_OUT_LOW: pin_out[g] <= 1'b0;
            `MCCT_OUT_HIGH: pin_out[g] <= 1'b1;
            `MCCT_OUT_TOG: pin_out[g] <= ~pin_out[g];
            default: pin_out[g] <= pin_out[g];
          endcase
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  cnt_hold_a: assert property (
    (!run_bits[0] && !preset[0] && !clr[0]) |=> $stable(cnt_value[15:0]))
    else $error("stopped counter moved");

  cnt_inc_a: assert property (
    (cnt_go[0] && !preset[0] && !clr[0])
    |=> cnt_value[15:0] == $past(cnt_value[15:0]) + 16'h1)
    else $error("counter did not step by one");

  ovf_wrap_a: assert property (
    (run_bits[2] && clk_sel[5:4] == `MCCT_CK_DIV1 && !preset[2] && !clr[2]
    && cnt_value[47:32] == `MCCT_CNT_MAX) |=> overflow_flag[2] && cnt_value[47:32] == 16'h0000)
    else $error("wrap did not set overflow");

  ovf_resume_a: assert property (
    (ovf[2] ##1 (cnt_go[2] && !preset[2] && !clr[2])) |=> cnt_value[47:32] == 16'h0001)
    else $error("count did not resume from zero");

  ovf_irq_a: assert property (
    (overflow_flag[2] && irq_ovf_en[2]) |=> irq_req[2])
    else $error("overflow irq missing");

  match_clr_a: assert property (
    (hit[0] && clr_cfg_r[2:0] == `MCCT_CLR_A && !preset[0])
    |=> cnt_value[15:0] == 16'h0000 && match_capture_flag[0])
    else $error("period match did not clear");

  match_irq_a: assert property (
    (match_capture_flag[0] && irq_match_en[0]) |=> irq_req[0])
    else $error("match irq missing");

  pin_tog_a: assert property (
    (hit[0] && gr_out_mode[1:0] == `MCCT_OUT_TOG) |=> pin_out[0] != $past(pin_out[0]))
    else $error("toggle not applied");

  pin_same_a: assert property (
    (hit[4] && gr_out_mode[9:8] == `MCCT_OUT_HIGH && pin_out[4]) |=> pin_out[4])
    else $error("equal level changed pin");

  cap_load_a: assert property (
    cap[0] |=> gr.q[0] == $past(cnt_value[15:0]))
    else $error("capture value wrong");

  sync_load_a: assert property (
    (cnt_wr_en && cnt_wr_chan == 3'h3 && sync_bits[3] && sync_bits[0])
    |=> cnt_value[15:0] == $past(cnt_wr_data) && cnt_value[63:48] == $past(cnt_wr_data))
    else $error("synchronous preset mismatch");

  buf_cmp_a: assert property (
    (hit[0] && buffer_en[0] && !cap[0]) |=> gr.q[0] == $past(gr.q[2]))
    else $error("buffer not transferred on match");

  buf_cap_a: assert property (
    (cap[0] && buffer_en[0]) |=> gr.q[2] == $past(gr.q[0]))
    else $error("old capture not moved to buffer");

  periodic_c: cover property (hit[0] && clr[0]);
  sync_clr_c: cover property (sync_evt && clr[1] && !own_clr[1]);
  buf_cap_c: cover property (cap[0] && buffer_en[0]);
  ovf_c: cover property (ovf[2]);
endmodule // mcct_top
`default_nettype wire

// ===== shared/mcct_cfg.svh
/*
  Constants of the six-channel capture/compare timer: encodings, field widths,
  reset values and the prescaler taps. Assumes inclusion by bare name.
*/
`ifndef MCCT_CFG_SVH
`define MCCT_CFG_SVH
`define MCCT_NCH 6
`define MCCT_NGR 24
`define MCCT_CNT_RST 16'h0000
`define MCCT_CNT_MAX 16'hFFFF
`define MCCT_CLR_W 3
`define MCCT_CLR_NONE 3'h0
`define MCCT_CLR_A 3'h1
`define MCCT_CLR_D 3'h4
`define MCCT_CLR_SYNC 3'h7
`define MCCT_OUT_NONE 2'h0
`define MCCT_OUT_LOW 2'h1
`define MCCT_OUT_HIGH 2'h2
`define MCCT_OUT_TOG 2'h3
`define MCCT_EDGE_RISE 2'h1
`define MCCT_EDGE_FALL 2'h2
`define MCCT_EDGE_BOTH 2'h3
`define MCCT_SRC_PIN 2'h0
`define MCCT_SRC_PCLK 2'h1
`define MCCT_SRC_PMATCH 2'h2
`define MCCT_CK_DIV1 2'h0
`define MCCT_CK_DIV4 2'h1
`define MCCT_CK_DIV16 2'h2
`define MCCT_CK_EXT 2'h3
`define MCCT_DIV4_TAP 2'h3
`define MCCT_DIV16_TAP 4'hF
`define MCCT_PRE_RST 4'h0
`endif

// ===== shared/mcct_pkg.sv
/*
  Types of the capture/compare timer. Assumes mcct_cfg.svh alongside.
*/
`include "mcct_cfg.svh"
package mcct_pkg;
  typedef logic [15:0] mcct_word_t;
  typedef logic [`MCCT_NCH-1:0] mcct_chmask_t;
  typedef logic [`MCCT_NGR-1:0] mcct_grmask_t;
  typedef logic [`MCCT_NGR-1:0][15:0] mcct_grbus_t;
  typedef logic [4:0] mcct_gridx_t;
  typedef logic [2:0] mcct_chidx_t;
endpackage

// ===== shared/mcct_gr_if.sv
/*
  Carrier between the timer core and its general register bank.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface mcct_gr_if;
  mcct_pkg::mcct_grmask_t we;
  mcct_pkg::mcct_grbus_t wd;
  mcct_pkg::mcct_grbus_t q;
  mcct_pkg::mcct_gridx_t rd_idx;
  mcct_pkg::mcct_word_t rd_data;
  modport bank (input we, input wd, input rd_idx, output q, output rd_data);
  modport ctl (output we, output wd, output rd_idx, input q, input rd_data);
endinterface
`default_nettype wire

// ===== core/mcct_gr_bank.sv
/*
  General register bank: 24 words, index = channel*4 + register.
  Assumes the core gates writes to absent registers; read data registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcct_cfg.svh"
module mcct_gr_bank (
  input wire logic clk_sys,
  input wire logic arst_n,
  mcct_gr_if.bank gr
);
  import mcct_pkg::*;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int g = 0; g < `MCCT_NGR; g++)
        gr.q[g] <= `MCCT_CNT_RST;
    end
    else
    begin
      for (int g = 0; g < `MCCT_NGR; g++)
        if (gr.we[g])
          gr.q[g] <= gr.wd[g];
    end
  end

  // Read port sees the value one edge after the index
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      gr.rd_data <= `MCCT_CNT_RST;
    else
      gr.rd_data <= gr.q[gr.rd_idx];
  end
endmodule // mcct_gr_bank
`default_nettype wire

// ===== dv/mcct_pin_model.sv
/*
  Far-side model of the capture pins: drives pin_in levels on command.
  Assumes the core samples pins on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module mcct_pin_model (
  input wire logic clk_sys,
  output var mcct_pkg::mcct_grmask_t pin_in
);
  import mcct_pkg::*;
  // Pins rest low; edges appear only when the bench orders them
  initial pin_in = '0;
  task automatic drive(input int idx, input logic lvl);
    @(posedge clk_sys);
    pin_in[idx] <= lvl;
  endtask
endmodule // mcct_pin_model
`default_nettype wire

// ===== dv/mcct_top_tb.sv
/*
  Self-checking bench of the capture/compare timer core.
  Assumes mcct_pin_model drives the capture pins; other inputs driven here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcct_cfg.svh"
module mcct_top_tb;
  import mcct_pkg::*;
  logic clk_sys, arst_n, cnt_wr_en, gr_wr_en;
  mcct_chmask_t run_bits, sync_bits, irq_ovf_en, ext_clk_in, flag_clr_ovf;
  logic [11:0] clk_sel;
  logic [17:0] clear_sel;
  mcct_grmask_t gr_capture_mode, irq_match_en, pin_in, flag_clr_match;
  logic [47:0] gr_out_mode, gr_edge_sel, gr_cap_src;
  logic [3:0] buffer_en;
  mcct_chidx_t cnt_wr_chan;
  mcct_word_t cnt_wr_data, gr_wr_data, gr_rd_data;
  mcct_gridx_t gr_wr_idx, gr_rd_idx;
  logic [95:0] cnt_value;
  mcct_chmask_t overflow_flag, irq_req;
  mcct_grmask_t match_capture_flag, pin_out, pin_oe;
  int n_fail = 0;
  int compares = 0;
  mcct_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .run_bits(run_bits), .sync_bits(sync_bits),
    .clk_sel(clk_sel), .clear_sel(clear_sel), .gr_capture_mode(gr_capture_mode), .gr_out_mode(gr_out_mode),
    .gr_edge_sel(gr_edge_sel), .gr_cap_src(gr_cap_src), .buffer_en(buffer_en), .irq_ovf_en(irq_ovf_en),
    .irq_match_en(irq_match_en), .ext_clk_in(ext_clk_in), .pin_in(pin_in), .cnt_wr_en(cnt_wr_en),
    .cnt_wr_chan(cnt_wr_chan), .cnt_wr_data(cnt_wr_data), .gr_wr_en(gr_wr_en), .gr_wr_idx(gr_wr_idx),
    .gr_wr_data(gr_wr_data), .gr_rd_idx(gr_rd_idx), .flag_clr_ovf(flag_clr_ovf),
    .flag_clr_match(flag_clr_match), .cnt_value(cnt_value), .gr_rd_data(gr_rd_data),
    .overflow_flag(overflow_flag), .match_capture_flag(match_capture_flag), .irq_req(irq_req),
    .pin_out(pin_out), .pin_oe(pin_oe));
  mcct_pin_model pm (.clk_sys(clk_sys), .pin_in(pin_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_up;
    n_fail++;
    complete_run();
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Full reset between scenarios keeps each one independent of the last
  task automatic reset_dut;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    {run_bits, sync_bits, irq_ovf_en, ext_clk_in, flag_clr_ovf, clk_sel, clear_sel} <= '0;
    {gr_capture_mode, irq_match_en, flag_clr_match, gr_out_mode, gr_edge_sel, gr_cap_src} <= '0;
    {buffer_en, cnt_wr_en, gr_wr_en, cnt_wr_chan, cnt_wr_data, gr_wr_idx, gr_wr_data, gr_rd_idx} <= '0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
  endtask
  task automatic cnt_wr(input mcct_chidx_t ch, input mcct_word_t d);
    @(posedge clk_sys);
    {cnt_wr_en, cnt_wr_chan, cnt_wr_data} <= {1'b1, ch, d};
    @(posedge clk_sys);
    cnt_wr_en <= 1'b0;
  endtask
  task automatic gr_wr(input mcct_gridx_t g, input mcct_word_t d);
    @(posedge clk_sys);
    {gr_wr_en, gr_wr_idx, gr_wr_data} <= {1'b1, g, d};
    @(posedge clk_sys);
    gr_wr_en <= 1'b0;
  endtask
  task automatic t_free_count;
    reset_dut();
    @(posedge clk_sys);
    run_bits <= 6'h3C;
    clk_sel <= {`MCCT_CK_EXT, `MCCT_CK_DIV1, `MCCT_CK_DIV16, `MCCT_CK_DIV4, 4'h0};
    step(8);
    check("cnt4", cnt_value[79:64], 16'h0008);
    check("cnt0", cnt_value[15:0], 16'h0000);
    check("cnt2 div4", cnt_value[47:32], 16'h0002);
    @(posedge clk_sys);
    ext_clk_in <= 6'h20;
    @(posedge clk_sys);
    ext_clk_in <= 6'h00;
    step(6);
    check("cnt4 more", cnt_value[79:64], 16'h0010);
    check("cnt3 div16", cnt_value[63:48], 16'h0001);
    check("cnt2 more", cnt_value[47:32], 16'h0004);
    check("cnt5 ext", cnt_value[95:80], 16'h0001);
  endtask
  task automatic t_overflow;
    int i;
    reset_dut();
    cnt_wr(3'h2, 16'hFFFE);
    @(posedge clk_sys);
    {irq_ovf_en, run_bits} <= {6'h04, 6'h04};
    for (i = 0; i < 10 && overflow_flag[2] !== 1'b1; i++) step(1);
    if (i == 10) give_up();
    check("wrap", cnt_value[47:32], 16'h0000);
    step(2);
    check("irq2", irq_req[2], 1'b1);
    check("cnt2 run", cnt_value[47:32], 16'h0002);
    @(posedge clk_sys);
    flag_clr_ovf <= 6'h04;
    @(posedge clk_sys);
    flag_clr_ovf <= 6'h00;
    step(1);
    check("ovf clr", overflow_flag[2], 1'b0);
    check("irq2 off", irq_req[2], 1'b0);
  endtask
  task automatic t_periodic;
    int i;
    reset_dut();
    gr_wr(5'h00, 16'h0003);
    @(posedge clk_sys);
    {gr_out_mode[1:0], clear_sel[2:0], irq_match_en[0]} <= {`MCCT_OUT_TOG, `MCCT_CLR_A, 1'b1};
    step(2);
    @(posedge clk_sys);
    run_bits <= 6'h01;
    for (i = 0; i < 20 && match_capture_flag[0] !== 1'b1; i++) step(1);
    if (i == 20) give_up();
    check("clr0", cnt_value[15:0], 16'h0000);
    check("pin0", {pin_oe[0], pin_out[0]}, 2'h3);
    step(1);
    check("irq0", irq_req[0], 1'b1);
    step(3);
    check("pin0 tog", pin_out[0], 1'b0);
    check("clr0 again", cnt_value[15:0], 16'h0000);
  endtask
  task automatic t_same_level;
    reset_dut();
    gr_wr(5'h04, 16'h0002);
    gr_wr(5'h05, 16'h0005);
    @(posedge clk_sys);
    gr_out_mode[11:8] <= {`MCCT_OUT_HIGH, `MCCT_OUT_HIGH};
    clear_sel[5:3] <= 3'h2;
    run_bits <= 6'h02;
    step(5);
    check("pin4", pin_out[4], 1'b1);
    step(4);
    check("pin4 hold", pin_out[4], 1'b1);
    check("cnt1 period", cnt_value[31:16], 16'h0003);
    check("flag5", match_capture_flag[5], 1'b1);
  endtask
  task automatic t_capture(input logic [1:0] c);
    reset_dut();
    @(posedge clk_sys);
    {gr_capture_mode[8], gr_edge_sel[17:16], gr_rd_idx} <= {1'b1, c, 5'h08};
    cnt_wr(3'h2, 16'h1230);
    pm.drive(8, 1'b1);
    step(3);
    check("cap rise", gr_rd_data, c[0] ? 16'h1230 : 16'h0000);
    cnt_wr(3'h2, 16'h4560);
    pm.drive(8, 1'b0);
    step(3);
    check("cap fall", gr_rd_data, c[1] ? 16'h4560 : (c[0] ? 16'h1230 : 16'h0000));
    check("cap flag", match_capture_flag[8], 1'b1);
  endtask
  task automatic t_sync_preset;
    int k;
    reset_dut();
    @(posedge clk_sys);
    sync_bits <= 6'h3F;
    cnt_wr(3'h3, 16'h5A5A);
    step(2);
    for (k = 0; k < 6; k++)
      check("sync cnt", cnt_value[16*k +: 16], 16'h5A5A);
  endtask
  // Partner clock undivided blocks capture; divided by four it captures
  task automatic t_partner;
    reset_dut();
    @(posedge clk_sys);
    {gr_capture_mode[0], gr_cap_src[1:0], run_bits} <= {1'b1, `MCCT_SRC_PCLK, 6'h01};
    step(6);
    check("pclk div1", match_capture_flag[0], 1'b0);
    @(posedge clk_sys);
    clk_sel[3:2] <= `MCCT_CK_DIV4;
    step(5);
    check("pclk cap", gr_rd_data, 16'h000A);
    check("pclk flag", match_capture_flag[0], 1'b1);
  endtask
  task automatic t_buffer;
    reset_dut();
    gr_wr(5'h00, 16'h0003);
    gr_wr(5'h02, 16'h0006);
    @(posedge clk_sys);
    {buffer_en, run_bits} <= {4'h1, 6'h01};
    step(5);
    check("buf cmp", gr_rd_data, 16'h0006);
    gr_wr(5'h02, 16'h0055);
    @(posedge clk_sys);
    {gr_capture_mode[0], gr_edge_sel[1:0], gr_rd_idx} <= {1'b1, `MCCT_EDGE_RISE, 5'h02};
    pm.drive(0, 1'b1);
    step(2);
    check("buf cap c", gr_rd_data, 16'h0006);
    @(posedge clk_sys);
    gr_rd_idx <= 5'h00;
    step(2);
    check("buf cap a", gr_rd_data, 16'h0009);
    // Pin back to rest so the next reset sees no false edge
    pm.drive(0, 1'b0);
  endtask
  task automatic t_sync_clear;
    reset_dut();
    gr_wr(5'h00, 16'h0003);
    @(posedge clk_sys);
    {sync_bits, clear_sel[5:0], run_bits} <= {6'h03, `MCCT_CLR_SYNC, `MCCT_CLR_A, 6'h03};
    step(4);
    check("sync clr0", cnt_value[15:0], 16'h0000);
    check("sync clr1", cnt_value[31:16], 16'h0000);
  endtask
  initial
  begin
    arst_n = 1'b0;
    reset_dut();
    t_free_count();
    t_overflow();
    t_periodic();
    t_same_level();
    t_capture(`MCCT_EDGE_RISE);
    t_capture(`MCCT_EDGE_FALL);
    t_capture(`MCCT_EDGE_BOTH);
    t_sync_preset();
    t_partner();
    t_buffer();
    t_sync_clear();
    complete_run();
  end
endmodule // mcct_top_tb
`default_nettype wire
